/* sctrc_defines.svh */
`ifndef SCTRC_DEFINES_SVH
`define SCTRC_DEFINES_SVH

// Register byte offsets
`define SCTRC_OFF_KEY0 8'h00
`define SCTRC_NKEY 5
`define SCTRC_OFF_GO 8'h14
`define SCTRC_OFF_RESULT 8'h18
`define SCTRC_OFF_EXTSTAT 8'h1c
`define SCTRC_OFF_LIMITS 8'h20

// Key sector codes
`define SCTRC_ACT_ERC 16'h0003
`define SCTRC_ACT_FEAT 16'h0004
`define SCTRC_FN_SET 16'h0001
`define SCTRC_FN_GET 16'h0002
`define SCTRC_FN_FLAGS 16'h0003
`define SCTRC_SEL_RD 16'h0001
`define SCTRC_SEL_WR 16'h0002
`define SCTRC_MIN_LIMIT 16'h0041
`define SCTRC_OPT_PERSIST_BIT 0

// Outcome codes
`define SCTRC_ERR_OK 8'h00
`define SCTRC_STAT_OK 8'h50
`define SCTRC_ERR_ABRT 8'h04
`define SCTRC_ERR_UNC 8'h40
`define SCTRC_STAT_ERR 8'h51
`define SCTRC_EXT_TMO 16'h0015
`define SCTRC_EXT_RST 16'h0000

// Reset values
`define SCTRC_LIMIT_RST 16'h0000
`define SCTRC_FEAT_DEF 16'h0001

// Timing
`define SCTRC_UNIT_MS 100
`define SCTRC_CLK_HZ 20000000
`define SCTRC_UNIT_CYCLES (`SCTRC_UNIT_MS * (`SCTRC_CLK_HZ / 1000))

// AXI responses
`define SCTRC_RESP_OKAY 2'h0
`define SCTRC_RESP_SLVERR 2'h2

`endif

/* sctrc_feat_store.sv */
`timescale 1ns/1ps
`include "sctrc_defines.svh"
module sctrc_feat_store
#(
    parameter int NFEAT = 4,
    parameter int IDX_W = 2
)
(
    // Clock and resets
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic pwr_nrst_i,
    // Update
    input wire logic wr_i,
    input wire logic [IDX_W-1:0] idx_i,
    input wire sctrc_pkg::sctrc_word_t state_i,
    input wire logic persist_i,
    // Readback of entry idx_i
    output sctrc_pkg::sctrc_word_t state_o,
    output sctrc_pkg::sctrc_word_t flags_o
);
    import sctrc_pkg::*;

    sctrc_word_t vol [NFEAT];
    sctrc_word_t nv [NFEAT];
    sctrc_word_t flg [NFEAT];

    // Non-volatile copy survives hard reset, only power-on reloads it with 0001h
    for (genvar i = 0; i < NFEAT; i++)
    begin : g_ent
        always_ff @(posedge clk_i)
        begin
            if (!pwr_nrst_i)
            begin
                vol[i] <= `SCTRC_FEAT_DEF;
                nv[i] <= `SCTRC_FEAT_DEF;
                flg[i] <= 16'h0000;
            end
            else if (!nrst_i)
                vol[i] <= nv[i]; // RL17
            else if (wr_i && idx_i == IDX_W'(i))
            begin
                vol[i] <= state_i; // RL15
                flg[i] <= {15'h0000, persist_i};
                if (persist_i)
                    nv[i] <= state_i; // RL16
            end
        end

        property p_persist;
            @(posedge clk_i) disable iff (!pwr_nrst_i || !nrst_i)
            wr_i && idx_i == IDX_W'(i) && persist_i |=> nv[i] == $past(state_i) && vol[i] == nv[i];
        endproperty
        a_persist: assert property (p_persist) else $error("Persistent set not retained"); // RL16

        property p_volatile;
            @(posedge clk_i) disable iff (!pwr_nrst_i || !nrst_i)
            wr_i && idx_i == IDX_W'(i) && !persist_i |=> $stable(nv[i]) && vol[i] == $past(state_i);
        endproperty
        a_volatile: assert property (p_volatile) else $error("Volatile set touched persistent copy"); // RL17
    end

    assign state_o = vol[idx_i];
    assign flags_o = flg[idx_i];
endmodule

/* sctrc_host_model.sv */
`timescale 1ns/1ps
module sctrc_host_model
(
    // Clock and request
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [1:0] kind_i,
    // Command pulse, kind bit0 read, bit1 streaming
    output logic start_o,
    output logic rd_o,
    output logic stream_o
);
    always_ff @(posedge clk_i)
    begin
        start_o <= go_i;
        rd_o <= kind_i[0];
        stream_o <= kind_i[1];
    end
endmodule

/* sctrc_pkg.sv */
package sctrc_pkg;
    typedef logic [15:0] sctrc_word_t;
    typedef logic [7:0] sctrc_byte_t;
    typedef enum logic [1:0] {SCTRC_IDLE = 2'b01, SCTRC_DECODE = 2'b10} sctrc_state_t;
    typedef enum logic [2:0] {SCTRC_TRK_IDLE = 3'b001, SCTRC_TRK_WAIT = 3'b010, SCTRC_TRK_RUN = 3'b100} sctrc_trk_t;
endpackage

/* sctrc_rec_timer.sv */
`timescale 1ns/1ps
module sctrc_rec_timer
#(
    parameter int UNIT_CYCLES = 2000000
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Control
    input wire logic start_i,
    input wire logic stop_i,
    input wire sctrc_pkg::sctrc_word_t limit_i,
    // Status
    output logic expire_o,
    output logic run_o
);
    import sctrc_pkg::*;

    localparam logic [31:0] PRE_LAST = 32'(UNIT_CYCLES - 1);
    logic [31:0] pre;
    sctrc_word_t units;
    sctrc_word_t lim;

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            run_o <= 1'b0;
            expire_o <= 1'b0;
            pre <= 32'h0;
            units <= 16'h0;
            lim <= 16'h0;
        end
        else
        begin
            expire_o <= 1'b0;
            // Zero limit never arms: timeout disabled
            if (start_i)
            begin
                run_o <= (limit_i != 16'h0); // RL9
                pre <= 32'h0;
                units <= 16'h0;
                lim <= limit_i;
            end
            else if (stop_i)
                run_o <= 1'b0;
            else if (run_o)
            begin
                if (pre == PRE_LAST)
                begin
                    pre <= 32'h0;
                    if (units == lim - 16'h0001)
                    begin
                        run_o <= 1'b0;
                        expire_o <= 1'b1; // RL10
                    end
                    else
                        units <= units + 16'h0001;
                end
                else
                    pre <= pre + 32'h1;
            end
        end
    end

    property p_expire_cause;
        @(posedge clk_i) disable iff (!nrst_i)
        expire_o |-> $past(run_o) && !run_o;
    endproperty
    a_expire_cause: assert property (p_expire_cause) else $error("Expiry without a running timer"); // RL10
endmodule

/* sctrc_top.sv */
`timescale 1ns/1ps
`include "sctrc_defines.svh"
// Behaviour
// (RL1) Action 3 is recovery control; function 1 stores, function 2 returns a limit.
// (RL2) Word 2 selects the read timer (1) or the write timer (2).
// (RL3) Word 3 of a set request is the limit in 100 ms units.
// (RL4) Set requests with limit below 65 units are aborted.
// (RL5) Success gives error 00h, status 50h; get returns limit in count/number.
// (RL6) Non-queued commands are timed up to host-interface completion.
// (RL7) In-order queued commands start timing when execution begins.
// (RL8) Streaming commands and out-of-order queued commands are never timed.
// (RL9) Limits are volatile, reset to zero; zero disables timeout.
// (RL10) On expiry the command is stopped; reads report uncorrectable error.
// (RL11) Write command expiry reports command aborted.
// (RL12) Any expiry loads extended status code 0015h.
// (RL13) Next non-SCT command clears that code, except an NCQ error log read.
// (RL14) Action 4 is feature control: set, return state, return option flags.
// (RL15) Word 2 is the feature code, word 3 the feature dependent state.
// (RL16) Option bit 0 set makes the new state survive power cycles; here it survives hard reset only, power-on reset restores 0001h.
// (RL17) Option bit 0 clear is volatile; hard reset restores the persistent setting.
// (RL18) Feature success gives 00h/50h; count/number carry state, flags or zero.
// (RL19) Unknown function, selection or feature codes abort and change nothing.
module sctrc_top
#(
    parameter int UNIT_CYCLES = `SCTRC_UNIT_CYCLES,
    parameter int NFEAT = 4
)
(
    // Clock and resets
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic PWR_NRST_I,
    // AXI4-Lite write address and data
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    // Drive command tracking
    input wire logic CMD_START_I,
    input wire logic CMD_IS_READ_I,
    input wire logic CMD_QUEUED_I,
    input wire logic CMD_STREAM_I,
    input wire logic OOO_EN_I,
    input wire logic CMD_EXEC_I,
    input wire logic CMD_DONE_I,
    input wire logic NCQ_LOG_READ_I,
    // Timeout report
    output logic TMO_O,
    output sctrc_pkg::sctrc_byte_t TMO_ERROR_O,
    output sctrc_pkg::sctrc_byte_t TMO_STATUS_O,
    output sctrc_pkg::sctrc_word_t EXT_STATUS_O
);
    import sctrc_pkg::*;

    localparam int IDX_W = (NFEAT > 1) ? $clog2(NFEAT) : 1;

    sctrc_state_t st;
    sctrc_trk_t trk;
    sctrc_word_t key [`SCTRC_NKEY];
    sctrc_word_t rd_lim;
    sctrc_word_t wr_lim;
    sctrc_byte_t res_err;
    sctrc_byte_t res_stat;
    sctrc_byte_t res_sc;
    sctrc_byte_t res_sn;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_hit;
    logic go;
    logic rd_hit;
    logic [31:0] rd_mux;
    logic trk_rd;
    logic tmr_start;
    logic tmr_rd;
    logic tmr_expire;
    logic tmr_run;
    sctrc_word_t tmr_lim;
    sctrc_word_t feat_state;
    sctrc_word_t feat_flags;
    logic feat_ok;
    logic [IDX_W-1:0] feat_idx;
    logic next_ok;
    logic next_set_rd;
    logic next_set_wr;
    logic next_feat_wr;
    sctrc_byte_t next_sc;
    sctrc_byte_t next_sn;

    // Write channel: address and data taken independently
    assign S_AXI_AWREADY_O = !aw_got && !S_AXI_BVALID_O;
    assign S_AXI_WREADY_O = !w_got && !S_AXI_BVALID_O;
    assign wr_fire = aw_got && w_got && !S_AXI_BVALID_O;
    assign wr_hit = (aw_addr == `SCTRC_OFF_GO) || (aw_addr[1:0] == 2'h0 &&
        aw_addr < 8'(`SCTRC_OFF_KEY0 + 4 * `SCTRC_NKEY));
    assign go = wr_fire && aw_addr == `SCTRC_OFF_GO && (|w_strb) && st == SCTRC_IDLE;

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            aw_got <= 1'b0;
            aw_addr <= 8'h00;
        end
        else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
        begin
            aw_got <= 1'b1;
            aw_addr <= S_AXI_AWADDR_I;
        end
        else if (wr_fire)
            aw_got <= 1'b0;
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            w_got <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end
        else if (S_AXI_WVALID_I && S_AXI_WREADY_O)
        begin
            w_got <= 1'b1;
            w_data <= S_AXI_WDATA_I;
            w_strb <= S_AXI_WSTRB_I;
        end
        else if (wr_fire)
            w_got <= 1'b0;
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= `SCTRC_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O <= wr_hit ? `SCTRC_RESP_OKAY : `SCTRC_RESP_SLVERR;
        end
        else if (S_AXI_BREADY_I)
            S_AXI_BVALID_O <= 1'b0;
    end

    // Key sector words, low two byte lanes only
    for (genvar i = 0; i < `SCTRC_NKEY; i++)
    begin : g_key
        always_ff @(posedge CLK_I)
        begin
            if (!NRST_I)
                key[i] <= 16'h0000;
            else if (wr_fire && aw_addr == 8'(`SCTRC_OFF_KEY0 + 4 * i))
            begin
                if (w_strb[0])
                    key[i][7:0] <= w_data[7:0];
                if (w_strb[1])
                    key[i][15:8] <= w_data[15:8];
            end
        end
    end

    // Read channel
    always_comb
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h0;
        case (S_AXI_ARADDR_I)
            `SCTRC_OFF_GO: rd_mux = {31'h0, st == SCTRC_DECODE};
            `SCTRC_OFF_RESULT: rd_mux = {res_sn, res_sc, res_stat, res_err};
            `SCTRC_OFF_EXTSTAT: rd_mux = {16'h0000, EXT_STATUS_O};
            `SCTRC_OFF_LIMITS: rd_mux = {wr_lim, rd_lim};
            default:
            begin
                if (S_AXI_ARADDR_I[1:0] == 2'h0 && S_AXI_ARADDR_I < 8'(`SCTRC_OFF_KEY0 + 4 * `SCTRC_NKEY))
                    rd_mux = {16'h0000, key[S_AXI_ARADDR_I[4:2]]};
                else
                    rd_hit = 1'b0;
            end
        endcase
    end

    assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h0;
            S_AXI_RRESP_O <= `SCTRC_RESP_OKAY;
        end
        else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
        begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O <= rd_mux;
            S_AXI_RRESP_O <= rd_hit ? `SCTRC_RESP_OKAY : `SCTRC_RESP_SLVERR;
        end
        else if (S_AXI_RREADY_I)
            S_AXI_RVALID_O <= 1'b0;
    end

    // Key sector decode, evaluated in the single decode cycle
    assign feat_ok = key[2] != 16'h0000 && key[2] <= 16'(NFEAT);
    assign feat_idx = IDX_W'(key[2] - 16'h0001);

    always_comb
    begin
        next_ok = 1'b0;
        next_set_rd = 1'b0;
        next_set_wr = 1'b0;
        next_feat_wr = 1'b0;
        next_sc = 8'h00;
        next_sn = 8'h00;
        if (key[0] == `SCTRC_ACT_ERC && (key[2] == `SCTRC_SEL_RD || key[2] == `SCTRC_SEL_WR)) // RL1 RL2 RL19
        begin
            if (key[1] == `SCTRC_FN_SET && key[3] >= `SCTRC_MIN_LIMIT) // RL3 RL4
            begin
                next_ok = 1'b1;
                next_set_rd = key[2] == `SCTRC_SEL_RD;
                next_set_wr = key[2] == `SCTRC_SEL_WR;
            end
            else if (key[1] == `SCTRC_FN_GET)
            begin
                next_ok = 1'b1;
                next_sc = (key[2] == `SCTRC_SEL_RD) ? rd_lim[7:0] : wr_lim[7:0]; // RL5
                next_sn = (key[2] == `SCTRC_SEL_RD) ? rd_lim[15:8] : wr_lim[15:8];
            end
        end
        else if (key[0] == `SCTRC_ACT_FEAT && feat_ok) // RL14 RL19
        begin
            case (key[1])
                `SCTRC_FN_SET:
                begin
                    next_ok = 1'b1;
                    next_feat_wr = 1'b1;
                end
                `SCTRC_FN_GET:
                begin
                    next_ok = 1'b1;
                    next_sc = feat_state[7:0]; // RL18
                    next_sn = feat_state[15:8];
                end
                `SCTRC_FN_FLAGS:
                begin
                    next_ok = 1'b1;
                    next_sc = feat_flags[7:0];
                    next_sn = feat_flags[15:8];
                end
                default: next_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            st <= SCTRC_IDLE;
        else
        begin
            case (st)
                SCTRC_IDLE: st <= go ? SCTRC_DECODE : SCTRC_IDLE;
                SCTRC_DECODE: st <= SCTRC_IDLE;
                default: st <= SCTRC_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            res_err <= `SCTRC_ERR_OK;
            res_stat <= `SCTRC_STAT_OK;
            res_sc <= 8'h00;
            res_sn <= 8'h00;
        end
        else if (st == SCTRC_DECODE)
        begin
            res_err <= next_ok ? `SCTRC_ERR_OK : `SCTRC_ERR_ABRT; // RL5 RL18 RL19
            res_stat <= next_ok ? `SCTRC_STAT_OK : `SCTRC_STAT_ERR;
            res_sc <= next_sc;
            res_sn <= next_sn;
        end
    end

    // Limits live only in flip-flops: lost on every hard reset
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            rd_lim <= `SCTRC_LIMIT_RST; // RL9
            wr_lim <= `SCTRC_LIMIT_RST;
        end
        else if (st == SCTRC_DECODE)
        begin
            if (next_set_rd)
                rd_lim <= key[3];
            if (next_set_wr)
                wr_lim <= key[3];
        end
    end

    sctrc_feat_store #(
        .NFEAT(NFEAT),
        .IDX_W(IDX_W)
    ) u_feat (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .pwr_nrst_i(PWR_NRST_I),
        .wr_i(st == SCTRC_DECODE && next_feat_wr),
        .idx_i(feat_idx),
        .state_i(key[3]),
        .persist_i(key[4][`SCTRC_OPT_PERSIST_BIT]),
        .state_o(feat_state),
        .flags_o(feat_flags)
    );

    // A new start replaces the tracked command, so back-to-back starts need no gap
    always_comb
    begin
        tmr_start = 1'b0;
        tmr_rd = trk_rd;
        if (CMD_START_I && !CMD_STREAM_I && !CMD_QUEUED_I) // RL6 RL8
        begin
            tmr_start = 1'b1;
            tmr_rd = CMD_IS_READ_I;
        end
        else if (!CMD_START_I && trk == SCTRC_TRK_WAIT && CMD_EXEC_I)
            tmr_start = 1'b1; // RL7
        tmr_lim = tmr_rd ? rd_lim : wr_lim;
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            trk <= SCTRC_TRK_IDLE;
            trk_rd <= 1'b0;
        end
        else if (CMD_START_I)
        begin
            trk_rd <= CMD_IS_READ_I;
            if (CMD_STREAM_I || (CMD_QUEUED_I && OOO_EN_I))
                trk <= SCTRC_TRK_IDLE; // RL8
            else if (CMD_QUEUED_I)
                trk <= SCTRC_TRK_WAIT; // RL7
            else
                trk <= SCTRC_TRK_RUN;
        end
        else
        begin
            case (trk)
                SCTRC_TRK_WAIT: trk <= CMD_DONE_I ? SCTRC_TRK_IDLE : (CMD_EXEC_I ? SCTRC_TRK_RUN : SCTRC_TRK_WAIT);
                SCTRC_TRK_RUN: trk <= (CMD_DONE_I || tmr_expire) ? SCTRC_TRK_IDLE : SCTRC_TRK_RUN;
                SCTRC_TRK_IDLE: trk <= SCTRC_TRK_IDLE;
                default: trk <= SCTRC_TRK_IDLE;
            endcase
        end
    end

    sctrc_rec_timer #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_tmr (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .start_i(tmr_start),
        .stop_i(CMD_DONE_I || (CMD_START_I && !tmr_start)),
        .limit_i(tmr_lim),
        .expire_o(tmr_expire),
        .run_o(tmr_run)
    );

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            TMO_O <= 1'b0;
            TMO_ERROR_O <= `SCTRC_ERR_OK;
            TMO_STATUS_O <= `SCTRC_STAT_OK;
        end
        else
        begin
            TMO_O <= tmr_expire; // RL10
            if (tmr_expire)
            begin
                TMO_ERROR_O <= trk_rd ? `SCTRC_ERR_UNC : `SCTRC_ERR_ABRT; // RL10 RL11
                TMO_STATUS_O <= `SCTRC_STAT_ERR;
            end
        end
    end

    // Expiry wins over the clear of a following command
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            EXT_STATUS_O <= `SCTRC_EXT_RST;
        else if (tmr_expire)
            EXT_STATUS_O <= `SCTRC_EXT_TMO; // RL12
        else if (CMD_START_I && !NCQ_LOG_READ_I)
            EXT_STATUS_O <= `SCTRC_EXT_RST; // RL13
    end

    sequence s_erc_low;
        st == SCTRC_DECODE && key[0] == `SCTRC_ACT_ERC && key[1] == `SCTRC_FN_SET && key[3] < `SCTRC_MIN_LIMIT;
    endsequence
    sequence s_aborted;
        res_err == `SCTRC_ERR_ABRT && res_stat == `SCTRC_STAT_ERR;
    endsequence

    property p_low_abort;
        @(posedge CLK_I) disable iff (!NRST_I)
        s_erc_low |=> s_aborted and ($stable(rd_lim) && $stable(wr_lim));
    endproperty
    a_low_abort: assert property (p_low_abort) else $error("Short limit not aborted"); // RL4

    property p_set_limit;
        @(posedge CLK_I) disable iff (!NRST_I)
        st == SCTRC_DECODE && key[0] == `SCTRC_ACT_ERC && key[1] == `SCTRC_FN_SET && key[2] == `SCTRC_SEL_WR
        && key[3] >= `SCTRC_MIN_LIMIT |=> wr_lim == $past(key[3]) && $stable(rd_lim) && res_stat == `SCTRC_STAT_OK;
    endproperty
    a_set_limit: assert property (p_set_limit) else $error("Write limit not stored"); // RL3

    property p_get_limit;
        @(posedge CLK_I) disable iff (!NRST_I)
        st == SCTRC_DECODE && key[0] == `SCTRC_ACT_ERC && key[1] == `SCTRC_FN_GET && key[2] == `SCTRC_SEL_RD
        |=> {res_sn, res_sc} == rd_lim && res_err == `SCTRC_ERR_OK && res_stat == `SCTRC_STAT_OK;
    endproperty
    a_get_limit: assert property (p_get_limit) else $error("Read limit not returned"); // RL5

    property p_bad_sel;
        @(posedge CLK_I) disable iff (!NRST_I)
        st == SCTRC_DECODE && key[0] == `SCTRC_ACT_ERC && key[2] != `SCTRC_SEL_RD && key[2] != `SCTRC_SEL_WR
        |=> s_aborted and ($stable(rd_lim) && $stable(wr_lim));
    endproperty
    a_bad_sel: assert property (p_bad_sel) else $error("Bad selection accepted"); // RL19

    property p_zero_off;
        @(posedge CLK_I) disable iff (!NRST_I)
        tmr_start && tmr_lim == 16'h0000 |=> !tmr_run [*2];
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("Zero limit armed timer"); // RL9

    property p_untimed;
        @(posedge CLK_I) disable iff (!NRST_I)
        CMD_START_I && (CMD_STREAM_I || (CMD_QUEUED_I && OOO_EN_I)) |=> trk == SCTRC_TRK_IDLE && !tmr_run;
    endproperty
    a_untimed: assert property (p_untimed) else $error("Untimed command timed"); // RL8

    property p_queued_wait;
        @(posedge CLK_I) disable iff (!NRST_I)
        CMD_START_I && CMD_QUEUED_I && !OOO_EN_I && !CMD_STREAM_I |=> trk == SCTRC_TRK_WAIT && !tmr_run;
    endproperty
    a_queued_wait: assert property (p_queued_wait) else $error("Queued command timed at arrival"); // RL7

    property p_tmo_report;
        @(posedge CLK_I) disable iff (!NRST_I)
        tmr_expire |=> TMO_O && EXT_STATUS_O == `SCTRC_EXT_TMO && TMO_STATUS_O == `SCTRC_STAT_ERR
        && TMO_ERROR_O == ($past(trk_rd) ? `SCTRC_ERR_UNC : `SCTRC_ERR_ABRT);
    endproperty
    a_tmo_report: assert property (p_tmo_report) else $error("Timeout outcome wrong"); // RL12

    property p_ext_clear;
        @(posedge CLK_I) disable iff (!NRST_I)
        CMD_START_I && !NCQ_LOG_READ_I && !tmr_expire |=> EXT_STATUS_O == `SCTRC_EXT_RST;
    endproperty
    property p_ext_keep;
        @(posedge CLK_I) disable iff (!NRST_I)
        CMD_START_I && NCQ_LOG_READ_I && !tmr_expire |=> $stable(EXT_STATUS_O);
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("Extended status not cleared"); // RL13
    a_ext_keep: assert property (p_ext_keep) else $error("Log read cleared extended status"); // RL13
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import sctrc_pkg::*;
    logic clk = 0, nrst = 0, pwr = 0, go = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, nlog = 0;
    logic [1:0] kind = 0, br, rr, rrs, brs;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, rdat;
    logic awr, wr, bv, arr, rv, tmo, st, rdk, sm, hit;
    sctrc_byte_t te, ts;
    sctrc_word_t ext;
    int err_total = 0, num_checks = 0, lim;
    always #25 clk = ~clk;
    sctrc_host_model HM (.clk_i(clk), .go_i(go), .kind_i(kind), .start_o(st), .rd_o(rdk), .stream_o(sm));
    sctrc_top #(.UNIT_CYCLES(2)) DUT (.CLK_I(clk), .NRST_I(nrst), .PWR_NRST_I(pwr), .S_AXI_AWADDR_I(awa),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I({4{wv}}),
        .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
        .S_AXI_BREADY_I(bre), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre),
        .CMD_START_I(st), .CMD_IS_READ_I(rdk), .CMD_QUEUED_I(1'b0), .CMD_STREAM_I(sm), .OOO_EN_I(1'b0),
        .CMD_EXEC_I(1'b0), .CMD_DONE_I(1'b0), .NCQ_LOG_READ_I(nlog), .TMO_O(tmo), .TMO_ERROR_O(te),
        .TMO_STATUS_O(ts), .EXT_STATUS_O(ext));
    function automatic logic [31:0] ok(input logic [15:0] v);
        return {v, 8'h50, 8'h00};
    endfunction
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic hang;
        err_total++;
        end_of_test;
    endtask
    // Handshakes sampled at the falling edge, where comb readies are settled
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        repeat (99)
        begin
            @(negedge clk);
            ta = awr;
            tw = wr;
            tb = bv;
            brs = br;
            @(posedge clk);
            if (ta)
                awv <= 0;
            if (tw)
                wv <= 0;
            if (tb)
            begin
                bre <= 0;
                return;
            end
        end
        hang;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        logic tr, tv;
        @(posedge clk);
        ara <= a;
        arv <= 1;
        rre <= 1;
        repeat (99)
        begin
            @(negedge clk);
            tr = arr;
            tv = rv;
            d = rdat;
            rrs = rr;
            @(posedge clk);
            if (tr)
                arv <= 0;
            if (tv)
            begin
                rre <= 0;
                return;
            end
        end
        hang;
    endtask
    task automatic sct(input logic [79:0] k, output logic [31:0] r);
        for (int i = 0; i < 5; i++)
            axw(8'(4 * i), {16'h0, k[16 * i +: 16]});
        axw(8'h14, 1);
        axr(8'h18, r);
    endtask
    task automatic run(input logic [1:0] k, input int n);
        @(posedge clk);
        kind <= k;
        go <= 1;
        @(posedge clk);
        go <= 0;
        hit = 0;
        repeat (n)
        begin
            @(negedge clk);
            if (tmo === 1'b1)
                hit = 1;
        end
    endtask
    initial
    begin
        void'($urandom(32'hae79));
        repeat (6) @(posedge clk);
        nrst <= 1;
        pwr <= 1;
        axr(8'h20, rd);
        cmp("limits", 0, rd);
        axr(8'h40, rd);
        cmp("rresp", 2, rrs);
        axw(8'h18, 0);
        cmp("bresp", 2, brs);
        run(1, 300);
        cmp("tmo", 0, hit);
        sct({16'h0, 16'd64, 16'h1, 16'h1, 16'h3}, rd);
        cmp("set64", 32'h5104, rd);
        sct({16'h0, 16'd65, 16'h1, 16'h1, 16'h3}, rd);
        cmp("set65", ok(0), rd);
        sct({16'h0, 16'h0, 16'h1, 16'h2, 16'h3}, rd);
        cmp("get", ok(65), rd);
        sct({16'h0, 16'd99, 16'h3, 16'h1, 16'h3}, rd);
        cmp("badsel", 32'h5104, rd);
        lim = 65 + $urandom % 60;
        sct({16'h0, 16'(lim), 16'h2, 16'h1, 16'h3}, rd);
        axr(8'h20, rd);
        cmp("limits", {16'(lim), 16'd65}, rd);
        $display("erc done");
        run(1, 300);
        cmp("tmo", 1, hit);
        cmp("terr", 8'h40, te);
        cmp("tstat", 8'h51, ts);
        cmp("ext", 16'h15, ext);
        @(posedge clk);
        nlog <= 1;
        run(0, 2);
        cmp("extkeep", 16'h15, ext);
        @(posedge clk);
        nlog <= 0;
        run(0, 2);
        cmp("extclr", 0, ext);
        run(0, 300);
        cmp("terr", 8'h04, te);
        run(2, 300);
        cmp("tmo", 0, hit);
        $display("timer done");
        sct({16'h1, 16'h3, 16'h2, 16'h1, 16'h4}, rd);
        cmp("fset", ok(0), rd);
        sct({16'h0, 16'h0, 16'h2, 16'h3, 16'h4}, rd);
        cmp("flags", ok(1), rd);
        sct({16'h0, 16'h5, 16'h2, 16'h1, 16'h4}, rd);
        sct({16'h0, 16'h0, 16'h2, 16'h2, 16'h4}, rd);
        cmp("fget", ok(5), rd);
        @(posedge clk);
        nrst <= 0;
        repeat (2) @(posedge clk);
        nrst <= 1;
        axr(8'h20, rd);
        cmp("limits", 0, rd);
        sct({16'h0, 16'h0, 16'h2, 16'h2, 16'h4}, rd);
        cmp("fkeep", ok(3), rd);
        sct({16'h0, 16'h0, 16'h2, 16'h9, 16'h4}, rd);
        cmp("badfn", 32'h5104, rd);
        $display("feature done");
        end_of_test;
    end
endmodule
